// >>> pkg/mfr_pkg.sv
`default_nettype none
package mfr_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_FIFO  = 4;
  localparam int WORD_W    = 10;
  localparam int DEPTH     = 32768;
  localparam int AW        = 15;
  localparam int CNT_W     = AW + 1;
  localparam int Q_W       = NUM_FIFO * WORD_W;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int WAKE_NS       = 1000;
  // least time, so round up
  localparam int WAKE_CYC      = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W    = 6;
  localparam int COMMIT_DLY    = 2;

  // ----------------------------------------------------------------
  // serial offset port
  // ----------------------------------------------------------------
  localparam int SER_OFS_BITS = 80;
  localparam logic [SER_OFS_BITS-1:0] OFS_RESET = {SER_OFS_BITS{1'b0}};

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic EMPTY_N_RESET = 1'b0;  // standard mode: empty
  localparam logic OR_N_RESET = 1'b1;  // fall-through: nothing ready

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef logic [WORD_W-1:0] mfr_word_t;

  typedef struct packed {
    logic read_enable_n;
    logic read_chip_select_n;
    logic output_enable_n;
  } mfr_rd_ctl_t;

  typedef struct packed {
    mfr_word_t data;
    logic      valid;
  } mfr_wr_t;
endpackage : mfr_pkg
`default_nettype wire

// >>> rtl/mfr_top.sv
// Operation
// - sdr reads one word per enabled edge
// - ddr reads rise and fall words
// - enables sampled on rising edges only
// - disabled cycle neither advances nor delivers, bar the fall-through first word
// - independent read enable per fifo
// - empty flag drops once drained, blocks reads
// - empty flag rises two cycles after write
// - ready flag rises once fully read
// - chip select low enables bus next edge
// - chip select high tristates, blocks read
// - oe low drives through reset, first edge
// - flags update regardless of chip select
// - fall-through word loads on third edge
// - rate pin sets sdr or ddr, static
// - fall word follows the rising enable
// - output enable gates bus per fifo
// - only output enable acts during reset
// - power-down freezes state, tristates outputs
// - wait after power-down release, no reset
// - serial load shifts on clock rise
// - serial readback shifts on clock rise
// - flag mode latched at master reset
// - four ten-bit lanes, fifo0 lowest
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// two-entry buffer on the write path
// ------------------------------------------------------------------
module mfr_buf2 #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  logic [W-1:0] slot_r [2];
  logic [1:0]   cnt_r;
  logic         head_r;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = slot_r[head_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // occupancy and head pointer
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r  <= 2'h0;
      head_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        head_r <= ~head_r;
      end
    end
  end

  // storage: tail slot is head plus count
  always_ff @(posedge clk) begin
    if (push) begin
      slot_r[head_r ^ cnt_r[0]] <= in_data;
    end
  end
endmodule : mfr_buf2

// ------------------------------------------------------------------
// one fifo channel, read side control
// ------------------------------------------------------------------
module mfr_chan
  import mfr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        active,
  input  wire logic        ft_mode,
  input  wire logic        ddr,
  input  wire logic        pwr_dn,
  input  wire mfr_wr_t     wr,
  output logic             wr_ready,
  input  wire logic        rd_en,
  output mfr_word_t        q_rise,
  output mfr_word_t        q_fall,
  output logic             fall_valid,
  output logic             flag_n
);
  mfr_word_t        mem [DEPTH];
  logic [CNT_W-1:0] wptr_r;
  logic [CNT_W-1:0] rptr_r;
  logic [CNT_W-1:0] avail_r;
  logic [CNT_W-1:0] avail_nxt;
  logic [COMMIT_DLY-1:0] commit_r;
  logic             flag_r;
  logic             flag_nxt;
  mfr_word_t        bw;
  logic             bv;
  logic             bready;
  logic             buf_ready;
  logic             wr_fire;
  logic             pop1;
  logic             pop2;
  logic [1:0]       pop_cnt;

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  // power-down blocks intake so the stalled buffer backs up the source
  assign wr_ready = buf_ready & active & ~pwr_dn;
  assign bready   = ~pwr_dn & ((wptr_r - rptr_r) != CNT_W'(DEPTH));
  assign wr_fire  = bv & bready;

  mfr_buf2 #(.W(WORD_W)) u_buf (
    .clk       (clk),
    .reset     (reset),
    .in_data   (wr.data),
    .in_valid  (wr.valid & active & ~pwr_dn),
    .in_ready  (buf_ready),
    .out_data  (bw),
    .out_valid (bv),
    .out_ready (bready)
  );

  // memory write
  always_ff @(posedge clk) begin
    if (wr_fire) begin
      mem[wptr_r[AW-1:0]] <= bw;
    end
  end

  // ----------------------------------------------------------------
  // read decision
  // ----------------------------------------------------------------
  // empty read idle
  always_comb begin
    pop1 = 1'b0;
    pop2 = 1'b0;
    if (!pwr_dn && active) begin
      if (ft_mode) begin
        pop1 = (flag_r | rd_en) && (avail_r != '0);
        pop2 = pop1 & rd_en & ~flag_r & ddr & (avail_r > CNT_W'(1));
      end else begin
        pop1 = rd_en & flag_r;
        pop2 = pop1 & ddr & (avail_r > CNT_W'(1));
      end
    end
  end

  assign pop_cnt   = {1'b0, pop1} + {1'b0, pop2};
  assign avail_nxt = avail_r + CNT_W'(commit_r[COMMIT_DLY-1]) - CNT_W'(pop_cnt);

  // flag next value, kept active low
  always_comb begin
    if (ft_mode) begin
      if (pop1) begin
        flag_nxt = 1'b0;
      end else if (rd_en && !flag_r) begin
        flag_nxt = 1'b1;
      end else begin
        flag_nxt = flag_r;
      end
    end else begin
      flag_nxt = (avail_nxt != '0);
    end
  end

  // ----------------------------------------------------------------
  // pointers, counts, flag
  // ----------------------------------------------------------------
  // frozen in power-down
  always_ff @(posedge clk) begin
    if (reset) begin
      wptr_r   <= '0;
      rptr_r   <= '0;
      avail_r  <= '0;
      commit_r <= '0;
      flag_r   <= ft_mode ? OR_N_RESET : EMPTY_N_RESET;
    end else if (!pwr_dn) begin
      if (wr_fire) begin
        wptr_r <= wptr_r + CNT_W'(1);
      end
      rptr_r   <= rptr_r + CNT_W'(pop_cnt);
      avail_r  <= avail_nxt;
      commit_r <= {commit_r[COMMIT_DLY-2:0], wr_fire};
      flag_r   <= flag_nxt;
    end
  end

  // output registers, fall word on its own q_fall bus
  always_ff @(posedge clk) begin
    if (reset) begin
      q_rise     <= '0;
      q_fall     <= '0;
      fall_valid <= 1'b0;
    end else if (!pwr_dn) begin
      if (pop1) begin
        q_rise <= mem[rptr_r[AW-1:0]];
      end
      if (pop2) begin
        q_fall <= mem[AW'(rptr_r[AW-1:0] + AW'(1))];
      end
      fall_valid <= pop2;
    end
  end

  // standard reset shows empty low; fall-through shows not ready high
  assign flag_n = ft_mode ? (flag_r | ~active) : flag_r;
endmodule : mfr_chan

// ------------------------------------------------------------------
// top: four channels, serial offsets, power-down
// ------------------------------------------------------------------
module mfr_top
  import mfr_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       partial_reset,
  input  wire logic                       dual_mode,
  input  wire logic                       read_rate_select,
  input  wire logic                       fallthrough_select_serial_in,
  input  wire logic                       power_down_n,
  input  wire mfr_wr_t [NUM_FIFO-1:0]     wr,
  output logic [NUM_FIFO-1:0]             wr_ready,
  input  wire mfr_rd_ctl_t [NUM_FIFO-1:0] rd_ctl,
  output logic [Q_W-1:0]                  q,
  output logic [Q_W-1:0]                  q_fall,
  output logic [NUM_FIFO-1:0]             q_fall_valid,
  output logic [NUM_FIFO-1:0]             q_oe,
  output logic [NUM_FIFO-1:0]             empty_flag_n,
  output logic                            fall_through_mode,
  input  wire logic                       serial_clk,
  input  wire logic                       serial_load_enable_n,
  input  wire logic                       serial_readback_enable_n,
  output logic                            serial_out,
  output logic                            serial_out_oe,
  output logic [SER_OFS_BITS-1:0]         offsets,
  output logic                            resume_ready
);
  logic                    pwr_dn;
  logic                    ddr_r;
  logic                    dual_r;
  logic                    hold_r;
  logic [NUM_FIFO-1:0]     sel_en_r;
  logic [NUM_FIFO-1:0]     active;
  logic [WAKE_CNT_W-1:0]   wake_cnt_r;
  logic                    sclk_q_r;
  logic                    rdbk_q_r;
  logic                    sclk_rise;
  logic [SER_OFS_BITS-1:0] scan_r;

  assign pwr_dn = ~power_down_n;

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // mode caught in reset
  always_ff @(posedge clk) begin
    if (reset) begin
      fall_through_mode <= fallthrough_select_serial_in;
      ddr_r             <= read_rate_select;
      dual_r            <= dual_mode;
    end
  end

  // ----------------------------------------------------------------
  // chip select and reset hold
  // ----------------------------------------------------------------
  // hold drive to first edge
  always_ff @(posedge clk) begin
    if (reset || partial_reset) begin
      hold_r <= 1'b1;
    end else if (!pwr_dn) begin
      hold_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || partial_reset) begin
      sel_en_r <= '0;
    end else if (!pwr_dn) begin
      for (int i = 0; i < NUM_FIFO; i++) begin
        sel_en_r[i] <= ~rd_ctl[i].read_chip_select_n;
      end
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  // one port per fifo
  for (genvar g = 0; g < NUM_FIFO; g++) begin : g_ch
    logic rd_en;
    // dual mode keeps fifo0 and fifo2 only
    assign active[g] = (g == 0) || (g == 2) || !dual_r;
    assign rd_en = ~rd_ctl[g].read_enable_n & ~rd_ctl[g].read_chip_select_n
                   & ~reset & ~partial_reset;
    assign q_oe[g] = ~pwr_dn & active[g] & ~rd_ctl[g].output_enable_n
                     & (hold_r | reset | partial_reset | sel_en_r[g]);

    mfr_chan u_ch (
      .clk        (clk),
      .reset      (reset | partial_reset),
      .active     (active[g]),
      .ft_mode    (fall_through_mode),
      .ddr        (ddr_r),
      .pwr_dn     (pwr_dn),
      .wr         (wr[g]),
      .wr_ready   (wr_ready[g]),
      .rd_en      (rd_en),
      .q_rise     (q[g*WORD_W +: WORD_W]),
      .q_fall     (q_fall[g*WORD_W +: WORD_W]),
      .fall_valid (q_fall_valid[g]),
      .flag_n     (empty_flag_n[g])
    );
  end

  // ----------------------------------------------------------------
  // power-down resume timer
  // ----------------------------------------------------------------
  // resume after interval
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_cnt_r <= '0;
    end else if (pwr_dn) begin
      wake_cnt_r <= WAKE_CNT_W'(WAKE_CYC);
    end else if (wake_cnt_r != '0) begin
      wake_cnt_r <= wake_cnt_r - WAKE_CNT_W'(1);
    end
  end

  // informative only; state continues without any reset
  assign resume_ready = ~pwr_dn & (wake_cnt_r == '0);

  // ----------------------------------------------------------------
  // serial offset port
  // ----------------------------------------------------------------
  // pins are synchronous, so edge detection needs no synchroniser
  assign sclk_rise = serial_clk & ~sclk_q_r & ~pwr_dn & ~reset;

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_q_r <= 1'b0;
      rdbk_q_r <= 1'b1;
    end else if (!pwr_dn) begin
      sclk_q_r <= serial_clk;
      rdbk_q_r <= serial_readback_enable_n;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      offsets <= OFS_RESET;
    end else if (sclk_rise && !serial_load_enable_n) begin
      offsets <= {fallthrough_select_serial_in, offsets[SER_OFS_BITS-1:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      scan_r <= OFS_RESET;
    end else if (!pwr_dn && !serial_readback_enable_n && rdbk_q_r) begin
      // fresh copy each time readback is enabled
      scan_r <= offsets;
    end else if (sclk_rise && !serial_readback_enable_n) begin
      scan_r <= {1'b0, scan_r[SER_OFS_BITS-1:1]};
    end
  end

  assign serial_out    = scan_r[0];
  assign serial_out_oe = ~pwr_dn & ~serial_readback_enable_n;
endmodule : mfr_top
`default_nettype wire

// >>> verif/mfr_top_props.sv
`timescale 1ns/1ns
`default_nettype none
module mfr_props
  import mfr_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic                       read_rate_select,
  input wire logic                       power_down_n,
  input wire mfr_rd_ctl_t [NUM_FIFO-1:0] rd_ctl,
  input wire logic [Q_W-1:0]             q,
  input wire logic [NUM_FIFO-1:0]        q_fall_valid,
  input wire logic [NUM_FIFO-1:0]        q_oe,
  input wire logic [NUM_FIFO-1:0]        wr_ready,
  input wire logic [NUM_FIFO-1:0]        empty_flag_n,
  input wire logic                       fall_through_mode,
  input wire logic                       serial_out_oe
);
  // ----
  // lane 1 watched
  // ----
  localparam int L = 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // two edges clear of reset, powered now and before: the select register is live
  sequence calm;
    !$past(reset) && !$past(reset, 2) && $past(power_down_n) && power_down_n;
  endsequence
  oe_gate_a: assert property (rd_ctl[L].output_enable_n |-> !q_oe[L])
    else $error("bus driven while oe high");
  sel_off_a: assert property (calm ##0 $past(rd_ctl[L].read_chip_select_n) |-> !q_oe[L])
    else $error("bus driven after select high");
  sel_on_a: assert property (calm ##0 !$past(rd_ctl[L].read_chip_select_n)
    && !rd_ctl[L].output_enable_n |-> q_oe[L]) else $error("bus idle after select low");
  sleep_quiet_a: assert property (!power_down_n |->
    q_oe == '0 && !serial_out_oe && wr_ready == '0) else $error("output live in power-down");
  sleep_freeze_a: assert property (!power_down_n && $past(!power_down_n) && !$past(reset)
    |-> $stable(q) && $stable(empty_flag_n)) else $error("state moved in power-down");
  read_hold_a: assert property (calm ##0 !fall_through_mode && ($past(
    rd_ctl[L].read_enable_n) || $past(rd_ctl[L].read_chip_select_n))
    |-> $stable(q[L*WORD_W +: WORD_W])) else $error("word moved without enable");
  empty_hold_a: assert property (calm ##0 !fall_through_mode && !$past(empty_flag_n[L])
    |-> $stable(q[L*WORD_W +: WORD_W])) else $error("word moved while empty");
  ddr_fall_a: assert property (q_fall_valid[L] |-> read_rate_select &&
    $past(!rd_ctl[L].read_enable_n && !rd_ctl[L].read_chip_select_n))
    else $error("fall word without enabled ddr read");
endmodule : mfr_props
bind mfr_top mfr_props u_props (.clk(clk), .reset(reset), .read_rate_select(read_rate_select),
  .power_down_n(power_down_n), .rd_ctl(rd_ctl), .q(q), .q_fall_valid(q_fall_valid),
  .q_oe(q_oe), .wr_ready(wr_ready), .empty_flag_n(empty_flag_n),
  .fall_through_mode(fall_through_mode), .serial_out_oe(serial_out_oe));
`default_nettype wire

// >>> verif/mfr_reader.sv
`timescale 1ns/1ns
`default_nettype none
module mfr_reader
  import mfr_pkg::*;
(
  input  wire logic      clk,
  input  wire mfr_word_t q_lane,
  output mfr_rd_ctl_t    ctl
);
  mfr_word_t got [0:7];
  initial ctl = '1;
  // change off rising edge; caller sits at a falling edge
  task automatic drive(input logic ren_n, input logic sel_n, input logic oe_n);
    ctl = {ren_n, sel_n, oe_n};
  endtask : drive
  task automatic idle(input int n);
    ctl.read_enable_n = 1'b1;
    repeat (n) @(negedge clk);
  endtask : idle
  // back-to-back reads, each word taken once the edge has landed
  task automatic pop(input int n);
    ctl.read_enable_n = 1'b0;
    ctl.read_chip_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      got[i] = q_lane;
    end
    ctl.read_enable_n = 1'b1;
  endtask : pop
endmodule : mfr_reader
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import mfr_pkg::*;
;
  logic                       clk = 1'b0;
  logic                       reset = 1'b1;
  logic                       rate = 1'b0;
  logic                       fsi = 1'b0;
  logic                       pwr_n = 1'b1;
  logic                       sclk = 1'b0;
  logic                       sle_n = 1'b1;
  logic                       sre_n = 1'b1;
  mfr_wr_t [NUM_FIFO-1:0]     wr = '0;
  mfr_rd_ctl_t                rctl;
  mfr_rd_ctl_t [NUM_FIFO-1:0] rd_ctl;
  logic [Q_W-1:0]             q, q_fall;
  logic [NUM_FIFO-1:0]        qfv, q_oe, wr_ready, efn;
  logic                       ftm, sout, sout_oe, res_rdy;
  logic [SER_OFS_BITS-1:0]    offsets, exp_ofs;
  int                         err_count = 0;
  int                         n_checks = 0;

  always #10 clk = ~clk;
  // only lane 1 has a reader; the rest stay deselected with bus off
  assign rd_ctl = {3'b111, 3'b111, rctl, 3'b111};

  mfr_top dut (.clk(clk), .reset(reset), .partial_reset(1'b0), .dual_mode(1'b0),
    .read_rate_select(rate), .fallthrough_select_serial_in(fsi), .power_down_n(pwr_n),
    .wr(wr), .wr_ready(wr_ready), .rd_ctl(rd_ctl), .q(q), .q_fall(q_fall),
    .q_fall_valid(qfv), .q_oe(q_oe), .empty_flag_n(efn), .fall_through_mode(ftm),
    .serial_clk(sclk), .serial_load_enable_n(sle_n), .serial_readback_enable_n(sre_n),
    .serial_out(sout), .serial_out_oe(sout_oe), .offsets(offsets), .resume_ready(res_rdy));
  mfr_reader rdr (.clk(clk), .q_lane(q[2*WORD_W-1:WORD_W]), .ctl(rctl));

  // ----
  // helpers
  // ----
  function automatic mfr_word_t ln1(input logic [Q_W-1:0] x);
    return x[2*WORD_W-1:WORD_W];
  endfunction : ln1
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [79:0] v, input logic [79:0] e);
    n_checks++;
    if (v !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, v, e);
    end
  endtask : chk
  task automatic give_up(input int t, input int lim);
    if (t >= lim) begin
      err_count++;
      wrap_up();
    end
  endtask : give_up
  // restrap rate under reset; oe low and select high to watch the bus
  task automatic restart(input logic r, input logic f);
    @(negedge clk);
    rdr.drive(1'b1, 1'b1, 1'b0);
    rate = r;
    fsi = f;
    reset = 1'b1;
    repeat (6) @(negedge clk);
    chk(q_oe[1], 1'b1);
    reset = 1'b0;
    // the hold lasts only up to the first edge after release
    #1 chk(q_oe[1], 1'b1);
    repeat (2) @(negedge clk);
    chk(q_oe[1], 1'b0);
  endtask : restart
  task automatic put(input int n, input mfr_word_t b);
    int t;
    for (int k = 0; k < n; k++) begin
      wr[1] = '{data: mfr_word_t'(b + k), valid: 1'b1};
      t = 0;
      while (wr_ready[1] !== 1'b1 && t < 20) begin
        @(negedge clk);
        t++;
      end
      give_up(t, 20);
      @(negedge clk);
    end
    wr[1] = '0;
  endtask : put
  task automatic wait_flag(input logic v);
    int t;
    t = 0;
    while (efn[1] !== v && t < 20) begin
      @(negedge clk);
      t++;
    end
    give_up(t, 20);
  endtask : wait_flag
  task automatic sclk_pulse();
    sclk = 1'b1;
    repeat (3) @(negedge clk);
    sclk = 1'b0;
    repeat (3) @(negedge clk);
  endtask : sclk_pulse

  // ----
  // scenarios
  // ----
  task automatic t_sdr();
    restart(1'b0, 1'b0);
    put(3, 10'h101);
    wait_flag(1'b1);
    chk(ln1(q), 10'h000);
    rdr.pop(3);
    for (int i = 0; i < 3; i++) chk(rdr.got[i], 10'h101 + i);
    chk(q[WORD_W-1:0], 10'h000);
    wait_flag(1'b0);
    // one edge between releasing and raising the enable again
    @(negedge clk);
    rdr.drive(1'b0, 1'b0, 1'b0);
    repeat (2) @(negedge clk);
    chk(ln1(q), 10'h103);
    chk(q_oe[1], 1'b1);
    rdr.drive(1'b1, 1'b0, 1'b1);
    #1 chk(q_oe[1], 1'b0);
    $display("t_sdr done");
  endtask : t_sdr
  task automatic t_ddr();
    restart(1'b1, 1'b0);
    put(3, 10'h201);
    wait_flag(1'b1);
    // flag rises on the first commit; let the other two land for a pair
    repeat (2) @(negedge clk);
    rdr.drive(1'b0, 1'b0, 1'b0);
    @(negedge clk);
    rdr.drive(1'b1, 1'b1, 1'b0);
    chk(ln1(q), 10'h201);
    chk(ln1(q_fall), 10'h202);
    chk(qfv[1], 1'b1);
    @(negedge clk);
    chk(qfv[1], 1'b0);
    $display("t_ddr done");
  endtask : t_ddr
  task automatic t_sleep();
    int t;
    rdr.idle(4);
    pwr_n = 1'b0;
    rdr.drive(1'b0, 1'b0, 1'b0);
    repeat (3) @(negedge clk);
    chk({q_oe, wr_ready, sout_oe}, 9'h000);
    chk({efn[1], ln1(q)}, {1'b1, 10'h201});
    rdr.drive(1'b1, 1'b1, 1'b0);
    pwr_n = 1'b1;
    t = 0;
    while (res_rdy !== 1'b1 && t < 100) begin
      @(negedge clk);
      t++;
    end
    give_up(t, 100);
    rdr.drive(1'b0, 1'b0, 1'b0);
    @(negedge clk);
    rdr.drive(1'b1, 1'b1, 1'b0);
    chk(ln1(q), 10'h203);
    chk(qfv[1], 1'b0);
    $display("t_sleep done");
  endtask : t_sleep
  // fall-through: first word loads with select high, then drains
  task automatic t_fall_through_mode();
    restart(1'b0, 1'b1);
    chk({ftm, efn[1]}, 2'h3);
    put(2, 10'h301);
    // ready flag moves with select high
    wait_flag(1'b0);
    chk(ln1(q), 10'h301);
    chk(q_oe[1], 1'b0);
    rdr.drive(1'b1, 1'b0, 1'b0);
    @(negedge clk);
    chk({q_oe[1], ln1(q)}, {1'b1, 10'h301});
    rdr.pop(2);
    chk(rdr.got[0], 10'h302);
    chk(rdr.got[1], 10'h302);
    chk(efn[1], 1'b1);
    $display("t_fall_through_mode done");
  endtask : t_fall_through_mode
  task automatic t_ser();
    sle_n = 1'b0;
    for (int i = 0; i < SER_OFS_BITS; i++) begin
      fsi = (i % 3 == 0);
      exp_ofs[i] = fsi;
      sclk_pulse();
    end
    chk(offsets, exp_ofs);
    sle_n = 1'b1;
    sre_n = 1'b0;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      chk(sout, exp_ofs[i]);
      sclk_pulse();
    end
    sre_n = 1'b1;
    $display("t_ser done");
  endtask : t_ser

  initial begin
    t_sdr();
    t_ddr();
    t_sleep();
    t_fall_through_mode();
    t_ser();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
